// ### core/omfd_regs.sv
// Offset monitor readback and 48 kHz rate window register bank
// Assumes a synchronous byte-wide control port and a compensator that presents monitors with a strobe
// Summary of operation
// - The left differential offset monitor low byte reads back read-only at its own address.
// - Monitor values are signed two's complement in 0.25 mV steps spanning -64.0 to 63.75 mV.
// - The left common-mode offset monitor reads as bit 8 in bit 0 of one register and bits 7-0 in the next.
// - A five-bit read/write minimum-count field of the 48 kHz window resets to zero.
// - A five-bit read/write maximum-count field of the 48 kHz window resets to zero.
// - The detector counts oscillator ticks per word clock period and flags 48 kHz inside the window.
// - The differential monitor bit 8 reads in bit 0 of the register below its low byte, upper bits reserved R/W.
`timescale 1ns/100ps
`include "omfd_map.svh"
module omfd_regs
  import omfd_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [8:0] differential_offset,
  input  wire logic [8:0] common_mode_feedback_offset,
  input  wire logic       monitor_update,
  input  wire logic       word_clk,
  input  wire logic       internal_oscillator,
  output logic            fs48_detected,
  output logic            fs48_result_valid
);
  omfd_det_if det_bus ();

  omfd_mon_t  differential_offset_mon_reg,  differential_offset_mon_next;
  omfd_mon_t  cm_mon_reg,    cm_mon_next;
  logic [6:0] differential_offset_rsvd_reg, differential_offset_rsvd_next;
  logic [6:0] cm_rsvd_reg,   cm_rsvd_next;
  omfd_byte_t min_reg,       min_next;
  omfd_byte_t max_reg,       max_next;
  omfd_byte_t rsvd_a_reg,    rsvd_a_next;
  omfd_byte_t rsvd_b_reg,    rsvd_b_next;
  omfd_byte_t rsvd_c_reg,    rsvd_c_next;
  omfd_byte_t rsvd_d_reg,    rsvd_d_next;
  omfd_byte_t rdata_reg,     rdata_next;
  logic       det_reg,       det_next;
  logic       dval_reg,      dval_next;

  // Register next-state
  always_comb begin
    differential_offset_mon_next  = differential_offset_mon_reg;
    cm_mon_next    = cm_mon_reg;
    differential_offset_rsvd_next = differential_offset_rsvd_reg;
    cm_rsvd_next   = cm_rsvd_reg;
    min_next       = min_reg;
    max_next       = max_reg;
    rsvd_a_next    = rsvd_a_reg;
    rsvd_b_next    = rsvd_b_reg;
    rsvd_c_next    = rsvd_c_reg;
    rsvd_d_next    = rsvd_d_reg;
    if (monitor_update) begin
      differential_offset_mon_next = differential_offset;
      cm_mon_next   = common_mode_feedback_offset;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        `OMFD_ADDR_DIFFERENTIAL_OFFSET_HIGH: differential_offset_rsvd_next = reg_wdata[`OMFD_HI_RSVD_MSB:`OMFD_HI_RSVD_LSB];
        `OMFD_ADDR_CM_HIGH:   cm_rsvd_next   = reg_wdata[`OMFD_HI_RSVD_MSB:`OMFD_HI_RSVD_LSB];
        `OMFD_ADDR_FS48_MIN:  min_next       = reg_wdata;
        `OMFD_ADDR_FS48_MAX:  max_next       = reg_wdata;
        `OMFD_ADDR_RSVD_A:    rsvd_a_next    = reg_wdata;
        `OMFD_ADDR_RSVD_B:    rsvd_b_next    = reg_wdata;
        `OMFD_ADDR_RSVD_C:    rsvd_c_next    = reg_wdata;
        `OMFD_ADDR_RSVD_D:    rsvd_d_next    = reg_wdata;
        default: ;
      endcase
    end
  end

  // Read path, registered; monitors are raw two's complement codes
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      unique case (reg_addr)
        `OMFD_ADDR_DIFFERENTIAL_OFFSET_HIGH: rdata_next = {differential_offset_rsvd_reg, differential_offset_mon_reg[`OMFD_MON_BIT8]};
        `OMFD_ADDR_DIFFERENTIAL_OFFSET_LOW:  rdata_next = differential_offset_mon_reg[`OMFD_MON_LOW_MSB:0];
        `OMFD_ADDR_CM_HIGH:   rdata_next = {cm_rsvd_reg, cm_mon_reg[`OMFD_MON_BIT8]};
        `OMFD_ADDR_CM_LOW:    rdata_next = cm_mon_reg[`OMFD_MON_LOW_MSB:0];
        `OMFD_ADDR_FS48_MIN:  rdata_next = min_reg;
        `OMFD_ADDR_FS48_MAX:  rdata_next = max_reg;
        `OMFD_ADDR_RSVD_A:    rdata_next = rsvd_a_reg;
        `OMFD_ADDR_RSVD_B:    rdata_next = rsvd_b_reg;
        `OMFD_ADDR_RSVD_C:    rdata_next = rsvd_c_reg;
        `OMFD_ADDR_RSVD_D:    rdata_next = rsvd_d_reg;
        default:              rdata_next = `OMFD_BYTE_RESET;
      endcase
    end
    det_next  = det_bus.is_48k;
    dval_next = det_bus.result_valid;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      differential_offset_mon_reg  <= `OMFD_MON_RESET;
      cm_mon_reg    <= `OMFD_MON_RESET;
      differential_offset_rsvd_reg <= `OMFD_HI_RSVD_RESET;
      cm_rsvd_reg   <= `OMFD_HI_RSVD_RESET;
      min_reg       <= `OMFD_BYTE_RESET;
      max_reg       <= `OMFD_BYTE_RESET;
      rsvd_a_reg    <= `OMFD_BYTE_RESET;
      rsvd_b_reg    <= `OMFD_BYTE_RESET;
      rsvd_c_reg    <= `OMFD_BYTE_RESET;
      rsvd_d_reg    <= `OMFD_BYTE_RESET;
      rdata_reg     <= `OMFD_BYTE_RESET;
      det_reg       <= 1'b0;
      dval_reg      <= 1'b0;
    end else begin
      differential_offset_mon_reg  <= differential_offset_mon_next;
      cm_mon_reg    <= cm_mon_next;
      differential_offset_rsvd_reg <= differential_offset_rsvd_next;
      cm_rsvd_reg   <= cm_rsvd_next;
      min_reg       <= min_next;
      max_reg       <= max_next;
      rsvd_a_reg    <= rsvd_a_next;
      rsvd_b_reg    <= rsvd_b_next;
      rsvd_c_reg    <= rsvd_c_next;
      rsvd_d_reg    <= rsvd_d_next;
      rdata_reg     <= rdata_next;
      det_reg       <= det_next;
      dval_reg      <= dval_next;
    end
  end

  assign det_bus.min_field = min_reg[`OMFD_WIN_MSB:0];
  assign det_bus.max_field = max_reg[`OMFD_WIN_MSB:0];
  assign reg_rdata         = rdata_reg;
  assign fs48_detected     = det_reg;
  assign fs48_result_valid = dval_reg;

  omfd_rate_det u_rate_det (
    .core_clk            (core_clk),
    .sys_rst             (sys_rst),
    .word_clk            (word_clk),
    .internal_oscillator (internal_oscillator),
    .det                 (det_bus)
  );

  a_differential_offset_low_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `OMFD_ADDR_DIFFERENTIAL_OFFSET_LOW) |=> reg_rdata == $past(differential_offset_mon_reg[7:0]))
    else $error("differential_offset low byte readback wrong");
  a_differential_offset_high_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `OMFD_ADDR_DIFFERENTIAL_OFFSET_HIGH) |=> reg_rdata == {$past(differential_offset_rsvd_reg), $past(differential_offset_mon_reg[8])})
    else $error("differential_offset high readback wrong");
  a_cm_split_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `OMFD_ADDR_CM_HIGH) |=> reg_rdata[0] == $past(cm_mon_reg[8]))
    else $error("cm bit 8 readback wrong");
  a_cm_low_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `OMFD_ADDR_CM_LOW) |=> reg_rdata == $past(cm_mon_reg[7:0]))
    else $error("cm low byte readback wrong");
  a_min_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `OMFD_ADDR_FS48_MIN) |=> min_reg[4:0] == $past(reg_wdata[4:0]))
    else $error("min window write lost");
  a_max_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `OMFD_ADDR_FS48_MAX) |=> det_bus.max_field == $past(reg_wdata[4:0]))
    else $error("max window write lost");
  a_mon_coherent: assert property (@(posedge core_clk) disable iff (sys_rst)
    monitor_update |=> differential_offset_mon_reg == $past(differential_offset) && cm_mon_reg == $past(common_mode_feedback_offset))
    else $error("monitor halves not captured together");
  a_mon_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    !monitor_update |=> $stable(differential_offset_mon_reg) && $stable(cm_mon_reg))
    else $error("monitor changed without update");
  c_mon_update: cover property (@(posedge core_clk) disable iff (sys_rst) monitor_update ##1 reg_rd);
  c_min_write: cover property (@(posedge core_clk) disable iff (sys_rst) reg_wr && reg_addr == `OMFD_ADDR_FS48_MIN);
  c_det_valid: cover property (@(posedge core_clk) disable iff (sys_rst) dval_reg);
endmodule : omfd_regs

// ### core/omfd_map.svh
// Register offsets, field positions, reset values and timing for the offset monitor / rate window bank
// Assumes an 8-bit register address and 8-bit data control port
`ifndef OMFD_MAP_SVH
`define OMFD_MAP_SVH
`define OMFD_ADDR_DIFFERENTIAL_OFFSET_HIGH    8'h4C
`define OMFD_ADDR_DIFFERENTIAL_OFFSET_LOW     8'h4D
`define OMFD_ADDR_FS48_MIN     8'h4E
`define OMFD_ADDR_RSVD_A       8'h4F
`define OMFD_ADDR_FS48_MAX     8'h50
`define OMFD_ADDR_RSVD_B       8'h51
`define OMFD_ADDR_RSVD_C       8'h52
`define OMFD_ADDR_RSVD_D       8'h53
`define OMFD_ADDR_CM_HIGH      8'h54
`define OMFD_ADDR_CM_LOW       8'h55
`define OMFD_BYTE_RESET        8'h00
`define OMFD_MON_RESET         9'h000
`define OMFD_HI_RSVD_MSB       7
`define OMFD_HI_RSVD_LSB       1
`define OMFD_MON_BIT8          8
`define OMFD_MON_LOW_MSB       7
`define OMFD_HI_RSVD_RESET     7'h00
`define OMFD_WIN_MSB           4
`define OMFD_WIN_RSVD_MSB      7
`define OMFD_WIN_RSVD_LSB      5
`define OMFD_FS48_MIN_DEFAULT  12'h35F
`define OMFD_FS48_MAX_DEFAULT  12'h9AF
`define OMFD_CNT_ZERO          12'h000
`define OMFD_CNT_ONE           12'h001
`define OMFD_CNT_SAT           12'hFFF
`define OMFD_WIN_SHIFT         7
`endif

// ### core/omfd_pkg.sv
// Types shared by the offset monitor / sample rate window bank
// Assumes omfd_map.svh holds the numeric constants
package omfd_pkg;
  typedef logic [7:0]  omfd_byte_t;
  typedef logic [8:0]  omfd_mon_t;
  typedef logic [11:0] omfd_cnt_t;
  typedef enum logic [1:0] {OMFD_WAIT_EDGE, OMFD_COUNT} omfd_det_e;
endpackage : omfd_pkg

// ### core/omfd_det_if.sv
// Carrier between the register bank and the sample rate detector
// Assumes one clock domain
`timescale 1ns/100ps
interface omfd_det_if;
  import omfd_pkg::*;
  logic [4:0] min_field;
  logic [4:0] max_field;
  logic       is_48k;
  logic       result_valid;
  modport bank (output min_field, output max_field, input is_48k, input result_valid);
  modport det  (input min_field, input max_field, output is_48k, output result_valid);
endinterface : omfd_det_if

// ### core/omfd_rate_det.sv
// Sample rate detector: counts oscillator ticks across one word clock period
// Assumes word clock and oscillator tick are synchronous to core_clk
`timescale 1ns/100ps
`include "omfd_map.svh"
module omfd_rate_det
  import omfd_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  sys_rst,
  input  wire logic  word_clk,
  input  wire logic  internal_oscillator,
  omfd_det_if.det    det
);
  omfd_det_e  state_reg,   state_next;
  omfd_cnt_t  count_reg,   count_next;
  logic       wclk_reg,    wclk_next;
  logic       hit_reg,     hit_next;
  logic       valid_reg,   valid_next;
  omfd_cnt_t  lo_lim;
  omfd_cnt_t  hi_lim;
  logic       rise;

  // Field scaled into oscillator count units
  function automatic omfd_cnt_t win_limit(input logic [4:0] f);
    win_limit = omfd_cnt_t'(f) << `OMFD_WIN_SHIFT;
  endfunction : win_limit

  // Tick on the opening edge belongs to the new period
  function automatic omfd_cnt_t start_count(input logic tick);
    start_count = tick ? `OMFD_CNT_ONE : `OMFD_CNT_ZERO;
  endfunction : start_count

  assign lo_lim = win_limit(det.min_field);
  assign hi_lim = win_limit(det.max_field);
  assign rise   = word_clk && !wclk_reg;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    wclk_next  = word_clk;
    hit_next   = hit_reg;
    valid_next = 1'b0;
    unique case (state_reg)
      OMFD_WAIT_EDGE: begin
        if (rise) begin
          state_next = OMFD_COUNT;
          count_next = start_count(internal_oscillator);
        end
      end
      OMFD_COUNT: begin
        if (rise) begin
          hit_next   = (count_reg >= lo_lim) && (count_reg <= hi_lim);
          valid_next = 1'b1;
          count_next = start_count(internal_oscillator);
        end else if (internal_oscillator && count_reg != `OMFD_CNT_SAT) begin
          count_next = count_reg + `OMFD_CNT_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= OMFD_WAIT_EDGE;
      count_reg <= `OMFD_CNT_ZERO;
      wclk_reg  <= 1'b0;
      hit_reg   <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      wclk_reg  <= wclk_next;
      hit_reg   <= hit_next;
      valid_reg <= valid_next;
    end
  end

  assign det.is_48k       = hit_reg;
  assign det.result_valid = valid_reg;

  a_window_hit: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_reg == OMFD_COUNT && rise) |=> hit_reg == ($past(count_reg) >= $past(lo_lim)
      && $past(count_reg) <= $past(hi_lim)))
    else $error("rate window classification wrong");
  c_det_hit: cover property (@(posedge core_clk) disable iff (sys_rst) valid_reg && hit_reg);
  c_det_miss: cover property (@(posedge core_clk) disable iff (sys_rst) valid_reg && !hit_reg);
endmodule : omfd_rate_det

// ### verif/offset_monitor_fs_detect_regs_tb_top.sv
// Self-checking bench for the offset monitor readback and 48 kHz window bank
// Assumes omfd_regs with its detector, the byte-wide strobe port and one 250 MHz clock
`timescale 1ns/100ps
`include "omfd_map.svh"
module offset_monitor_fs_detect_regs_tb_top
  import omfd_pkg::*;
;
  logic       core_clk   = 1'b0;
  logic       sys_rst    = 1'b1;
  omfd_byte_t reg_addr   = 8'h00;
  omfd_byte_t reg_wdata  = 8'h00;
  logic       reg_wr     = 1'b0;
  logic       reg_rd     = 1'b0;
  omfd_byte_t reg_rdata;
  omfd_mon_t  differential_offset_in    = 9'h000;
  omfd_mon_t  cm_in      = 9'h000;
  logic       mon_upd    = 1'b0;
  logic       word_clk   = 1'b0;
  logic       osc_tick   = 1'b0;
  logic       det;
  logic       det_valid;
  logic       last_det   = 1'b0;
  int         failures   = 0;
  int         n_compared = 0;
  int         n_valid    = 0;

  omfd_regs u_dut (
    .core_clk                    (core_clk),
    .sys_rst                     (sys_rst),
    .reg_addr                    (reg_addr),
    .reg_wdata                   (reg_wdata),
    .reg_wr                      (reg_wr),
    .reg_rd                      (reg_rd),
    .reg_rdata                   (reg_rdata),
    .differential_offset         (differential_offset_in),
    .common_mode_feedback_offset (cm_in),
    .monitor_update              (mon_upd),
    .word_clk                    (word_clk),
    .internal_oscillator         (osc_tick),
    .fs48_detected               (det),
    .fs48_result_valid           (det_valid)
  );

  always #2 core_clk = ~core_clk;

  // Latch each classification once the edge's updates have landed
  always @(posedge core_clk) begin
    #1;
    if (det_valid === 1'b1) begin
      n_valid++;
      last_det = det;
    end
  end

  task report_and_stop();
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task chk(input omfd_byte_t got, input omfd_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input omfd_byte_t a, input omfd_byte_t d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task rchk(input omfd_byte_t a, input omfd_byte_t exp);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rchk

  task mon_load(input omfd_mon_t d, input omfd_mon_t c);
    @(posedge core_clk);
    differential_offset_in <= d;
    cm_in   <= c;
    mon_upd <= 1'b1;
    @(posedge core_clk);
    mon_upd <= 1'b0;
    // Inputs move on without a strobe; registers must not follow
    differential_offset_in <= ~d;
    cm_in   <= ~c;
  endtask : mon_load

  task test_reset();
    chk({6'h00, det, det_valid}, 8'h00);
    for (int a = 'h4C; a <= 'h56; a++) begin
      rchk(8'(a), 8'h00);
    end
  endtask : test_reset

  task test_monitors();
    mon_load(9'h1FF, 9'h100);
    rchk(`OMFD_ADDR_DIFFERENTIAL_OFFSET_HIGH, 8'h01);
    rchk(`OMFD_ADDR_DIFFERENTIAL_OFFSET_LOW, 8'hFF);
    rchk(`OMFD_ADDR_CM_HIGH, 8'h01);
    rchk(`OMFD_ADDR_CM_LOW, 8'h00);
    wr(`OMFD_ADDR_DIFFERENTIAL_OFFSET_LOW, 8'h5A);
    rchk(`OMFD_ADDR_DIFFERENTIAL_OFFSET_LOW, 8'hFF);
    wr(`OMFD_ADDR_CM_LOW, 8'h5A);
    rchk(`OMFD_ADDR_CM_LOW, 8'h00);
    wr(`OMFD_ADDR_DIFFERENTIAL_OFFSET_HIGH, 8'hFE);
    rchk(`OMFD_ADDR_DIFFERENTIAL_OFFSET_HIGH, 8'hFF);
    wr(`OMFD_ADDR_CM_HIGH, 8'hA4);
    rchk(`OMFD_ADDR_CM_HIGH, 8'hA5);
    mon_load(9'h0AA, 9'h055);
    rchk(`OMFD_ADDR_DIFFERENTIAL_OFFSET_HIGH, 8'hFE);
    rchk(`OMFD_ADDR_DIFFERENTIAL_OFFSET_LOW, 8'hAA);
    rchk(`OMFD_ADDR_CM_HIGH, 8'hA4);
    rchk(`OMFD_ADDR_CM_LOW, 8'h55);
  endtask : test_monitors

  task test_window();
    omfd_byte_t rsvd [4];
    rsvd = '{`OMFD_ADDR_RSVD_A, `OMFD_ADDR_RSVD_B, `OMFD_ADDR_RSVD_C, `OMFD_ADDR_RSVD_D};
    wr(`OMFD_ADDR_FS48_MIN, 8'hFF);
    rchk(`OMFD_ADDR_FS48_MIN, 8'hFF);
    wr(`OMFD_ADDR_FS48_MAX, 8'hE3);
    rchk(`OMFD_ADDR_FS48_MAX, 8'hE3);
    foreach (rsvd[i]) begin
      wr(rsvd[i], rsvd[i] ^ 8'hA5);
      rchk(rsvd[i], rsvd[i] ^ 8'hA5);
    end
    wr(8'h60, 8'h77);
    rchk(8'h60, 8'h00);
  endtask : test_window

  task period(input int n);
    @(posedge core_clk);
    word_clk <= 1'b1;
    repeat (n / 2) @(posedge core_clk);
    word_clk <= 1'b0;
    repeat (n - n / 2 - 1) @(posedge core_clk);
  endtask : period

  // Third rise closes a clean period of n oscillator ticks
  task det_case(input int n, input logic exp);
    int v0;
    v0 = n_valid;
    repeat (3) period(n);
    chk({7'h00, last_det}, {7'h00, exp});
    chk(8'(n_valid - v0), 8'h03);
  endtask : det_case

  task test_detect();
    wr(`OMFD_ADDR_FS48_MIN, 8'h02);
    wr(`OMFD_ADDR_FS48_MAX, 8'h03);
    period(100);
    det_case(100, 1'b0);
    det_case(255, 1'b0);
    det_case(256, 1'b1);
    det_case(320, 1'b1);
    det_case(384, 1'b1);
    det_case(385, 1'b0);
    det_case(600, 1'b0);
    wr(`OMFD_ADDR_FS48_MAX, 8'h1F);
    det_case(3000, 1'b1);
    det_case(4200, 1'b0);
  endtask : test_detect

  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst  <= 1'b0;
    osc_tick <= 1'b1;
    test_reset();
    test_monitors();
    test_window();
    test_detect();
    report_and_stop();
  end

  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule : offset_monitor_fs_detect_regs_tb_top
